// ===== logic/hpb_pkg.sv
`default_nettype none
package hpb_pkg;
	// ==========================================
	// widths
	localparam int AD_W = 8;
	localparam int A_W = 4;
	localparam int RT_SRC_W = 4;
	localparam int GEN_SRC_W = 8;
	// ==========================================
	// reset values
	localparam logic [AD_W-1:0] AD_RST = 8'h00;
	localparam logic MUX_MODE_RST = 1'b0;
	// ==========================================
	// bus control style
	typedef enum logic {
		HPB_STYLE_SINGLE = 1'b0,
		HPB_STYLE_SPLIT = 1'b1
	} hpb_style_t;
endpackage
`default_nettype wire

// ===== logic/hpb_acc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hpb_acc_if;
	logic act;
	logic start;
	logic fin;
	logic is_rd;
	modport dec (output act, output start, output fin, output is_rd);
	modport core (input act, input start, input fin, input is_rd);
endinterface
`default_nettype wire

// ===== logic/hpb_strobe_dec.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_strobe_dec (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_strobe_n,
	input wire logic i_dir,
	input wire hpb_pkg::hpb_style_t i_style,
	hpb_acc_if.dec acc
);
	logic act;
	logic rd_now;
	logic act_q;
	logic rd_q;

	// ==========================================
	// access decode
	always_comb begin
		if (i_style == hpb_pkg::HPB_STYLE_SINGLE) begin
			act = !i_cs_n && !i_strobe_n;
			rd_now = i_dir;
		end else begin
			act = !i_cs_n && (!i_strobe_n || !i_dir);
			rd_now = !i_strobe_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			act_q <= 1'b0;
		end else begin
			act_q <= act;
		end
	end

	// direction is sampled every cycle of the access and the last value is held after its end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_q <= 1'b0;
		end else if (act) begin
			rd_q <= rd_now;
		end
	end

	assign acc.act = act;
	assign acc.start = act && !act_q;
	assign acc.fin = act_q && !act;
	assign acc.is_rd = act ? rd_now : rd_q;
endmodule
`default_nettype wire

// ===== logic/hpb_host_port.sv
// Notes on behaviour
// - In multiplexed mode the shared eight lines first carry the address, then data both ways.
// - In demultiplexed mode the shared lines carry only data and no address is taken from them.
// - In demultiplexed mode the address comes from the four dedicated address inputs.
// - In single-strobe style an access ends at the rising strobe edge, which completes a write or ends a read drive.
// - In single-strobe style the direction input is high for a read and low for a write during the access.
// - In split-strobe style the read strobe means read and the write strobe means write.
// - In multiplexed mode the address is captured from the shared lines while address latch is high.
// - The address latch input decides between multiplexed and demultiplexed operation.
// - High-priority conditions drive the dedicated open-drain real-time interrupt output.
// - All other conditions drive the separate open-drain interrupt request output.
`timescale 1ns/100ps
`default_nettype none
module hpb_host_port #(
	parameter int AD_W = hpb_pkg::AD_W,
	parameter int A_W = hpb_pkg::A_W,
	parameter int RT_SRC_W = hpb_pkg::RT_SRC_W,
	parameter int GEN_SRC_W = hpb_pkg::GEN_SRC_W
) (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RST,

	// host bus
	input wire logic I_STYLE_SPLIT,
	input wire logic I_CS_N,
	input wire logic I_HOST_DATA_STROBE_N,
	input wire logic I_DIR_OR_WR_N,
	input wire logic I_ALE,
	input wire logic [A_W-1:0] I_A,
	input wire logic [AD_W-1:0] I_AD,
	output logic [AD_W-1:0] O_AD,
	output logic O_AD_OE,

	// internal register side
	output logic O_REG_WR,
	output logic O_REG_RD,
	output logic [AD_W-1:0] O_REG_ADDR,
	output logic [AD_W-1:0] O_REG_WDATA,
	input wire logic [AD_W-1:0] I_REG_RDATA,

	// interrupt sources and pins
	input wire logic [RT_SRC_W-1:0] I_RT_PEND,
	input wire logic [GEN_SRC_W-1:0] I_GEN_PEND,
	output logic O_REALTIME_IRQ_OUT,
	output logic O_REALTIME_IRQ_OUT_OE,
	output logic O_IRQ_REQ,
	output logic O_IRQ_REQ_OE,

	// status
	output logic O_MUX_MODE
);
	// ==========================================
	// access state
	hpb_acc_if acc ();
	hpb_pkg::hpb_style_t style;

	// mode and address
	logic mux_mode_q;
	logic [AD_W-1:0] addr_q;

	// write side
	logic [AD_W-1:0] wdata_q;
	logic wr_q;

	// read side
	logic [AD_W-1:0] rdata_q;
	logic oe_q;
	logic rd_q;
	logic rd_fetch_q;

	// interrupt lines, index 0 real-time, index 1 general request
	localparam int IRQ_N = 2;
	logic [IRQ_N-1:0] irq_any;
	logic [IRQ_N-1:0] irq_q;

	// ==========================================
	// decode helpers
	// a write is any access that is not a read; used for data capture and the end pulse
	function automatic logic is_write(input logic qual, input logic rd);
		return qual && !rd;
	endfunction

	// ==========================================
	// bus style
	// the strap selects single strobe plus direction or separate read and write strobes
	assign style = I_STYLE_SPLIT ? hpb_pkg::HPB_STYLE_SPLIT : hpb_pkg::HPB_STYLE_SINGLE;

	// ==========================================
	// strobe decode
	hpb_strobe_dec u_dec (
		.i_clk(I_MCLK),
		.i_rst(I_RST),
		.i_cs_n(I_CS_N),
		.i_strobe_n(I_HOST_DATA_STROBE_N),
		.i_dir(I_DIR_OR_WR_N),
		.i_style(style),
		.acc(acc)
	);

	// ==========================================
	// mode selection
	// any address latch pulse switches the port to multiplexed operation
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			mux_mode_q <= hpb_pkg::MUX_MODE_RST;
		end else if (I_ALE) begin
			mux_mode_q <= 1'b1;
		end
	end

	// ==========================================
	// address capture
	// demultiplexed addresses are zero-extended to the internal address width
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			addr_q <= hpb_pkg::AD_RST;
		end else if (I_ALE) begin
			addr_q <= I_AD;
		end else if (!mux_mode_q && acc.start) begin
			addr_q <= {{(AD_W-A_W){1'b0}}, I_A};
		end
	end

	// ==========================================
	// write data path
	// the last value sampled before the strobe rises is the one written
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			wdata_q <= hpb_pkg::AD_RST;
		end else if (is_write(acc.act, acc.is_rd)) begin
			wdata_q <= I_AD;
		end
	end

	// ==========================================
	// write strobe
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= is_write(acc.fin, acc.is_rd);
		end
	end

	// ==========================================
	// read request
	// the internal location gets two cycles to answer before its data is taken
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			rd_q <= 1'b0;
		end else begin
			rd_q <= acc.start && acc.is_rd;
		end
	end

	// ==========================================
	// read fetch
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			rd_fetch_q <= 1'b0;
		end else begin
			rd_fetch_q <= rd_q;
		end
	end

	// ==========================================
	// read data capture
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			rdata_q <= hpb_pkg::AD_RST;
		end else if (rd_fetch_q) begin
			rdata_q <= I_REG_RDATA;
		end
	end

	// drive stops once the strobe rises or chip select goes away
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= acc.act && acc.is_rd;
		end
	end

	// ==========================================
	// interrupt lines, open drain: value low, enable while pending
	// each line is the or of its own pending group, so the two never mix
	assign irq_any[0] = |I_RT_PEND;
	assign irq_any[1] = |I_GEN_PEND;

	for (genvar g = 0; g < IRQ_N; g++) begin : g_irq
		always_ff @(posedge I_MCLK) begin
			if (I_RST) begin
				irq_q[g] <= 1'b0;
			end else begin
				irq_q[g] <= irq_any[g];
			end
		end
	end

	// ==========================================
	// outputs
	assign O_AD = rdata_q;
	assign O_AD_OE = oe_q;

	// internal register side
	assign O_REG_WR = wr_q;
	assign O_REG_RD = rd_q;
	assign O_REG_ADDR = addr_q;
	assign O_REG_WDATA = wdata_q;

	// open-drain pins only ever pull low
	assign O_REALTIME_IRQ_OUT = 1'b0;
	assign O_REALTIME_IRQ_OUT_OE = irq_q[0];
	assign O_IRQ_REQ = 1'b0;
	assign O_IRQ_REQ_OE = irq_q[1];

	// status
	assign O_MUX_MODE = mux_mode_q;
endmodule
`default_nettype wire

// ===== verif/hpb_host_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_host_port_assertions (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_STYLE_SPLIT,
	input wire logic I_CS_N,
	input wire logic I_HOST_DATA_STROBE_N,
	input wire logic I_DIR_OR_WR_N,
	input wire logic I_ALE,
	input wire logic [3:0] I_RT_PEND,
	input wire logic [7:0] I_GEN_PEND,
	input wire logic O_AD_OE,
	input wire logic O_REG_WR,
	input wire logic O_REG_RD,
	input wire logic O_REALTIME_IRQ_OUT_OE,
	input wire logic O_IRQ_REQ_OE,
	input wire logic O_MUX_MODE
);
	default clocking @(posedge I_MCLK);
	endclocking
	default disable iff (I_RST);
	wire logic act = !I_CS_N && (!I_HOST_DATA_STROBE_N || (I_STYLE_SPLIT && !I_DIR_OR_WR_N));
	a_rt_irq: assert property (!$past(I_RST) |-> O_REALTIME_IRQ_OUT_OE == |$past(I_RT_PEND)) else $error("rt");
	a_gen_irq: assert property (!$past(I_RST) |-> O_IRQ_REQ_OE == |$past(I_GEN_PEND)) else $error("gen");
	a_read_start: assert property ($rose(act) && I_DIR_OR_WR_N |=> O_REG_RD) else $error("rd");
	a_write_end: assert property ($fell(act) && !$past(I_DIR_OR_WR_N) |=> O_REG_WR) else $error("wr");
	a_drive_end: assert property ($fell(act) |=> !O_AD_OE) else $error("oe");
	a_drive_cs: assert property (O_AD_OE |-> !$past(I_CS_N)) else $error("cs");
	a_mode_sticky: assert property (I_ALE || O_MUX_MODE |=> O_MUX_MODE) else $error("mode");
	a_quiet_idle: assert property (I_CS_N && $past(I_CS_N) |=> !O_REG_RD && !O_REG_WR) else $error("idle");
	c_read: cover property (O_REG_RD);
	c_write: cover property (O_REG_WR);
	c_mux: cover property ($rose(O_MUX_MODE));
endmodule
bind hpb_host_port hpb_host_port_assertions u_chk (.*);
`default_nettype wire

// ===== verif/hpb_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_host_model (
	input wire logic i_clk,
	input wire logic i_oe,
	input wire logic [7:0] i_ad,
	output logic o_sp = 1'b0,
	output logic o_cs_n = 1'b1,
	output logic o_ds_n = 1'b1,
	output logic o_dw_n = 1'b1,
	output logic o_al = 1'b0,
	output logic [3:0] o_a = 4'h0,
	output logic [7:0] o_ad = 8'h00
);
	task automatic xfer(input logic c, s, m, w, input logic [7:0] adr, wd, output logic [7:0] rd);
		o_sp <= s;
		if (m) begin
			o_al <= 1'b1;
			o_ad <= adr;
			@(posedge i_clk);
		end
		o_al <= 1'b0;
		o_cs_n <= !c;
		o_ds_n <= s & w;
		o_dw_n <= !w;
		o_a <= adr[3:0];
		o_ad <= w ? wd : ~adr;
		repeat (6) @(posedge i_clk);
		rd = i_oe ? i_ad : 'x;
		o_cs_n <= 1'b1;
		o_ds_n <= 1'b1;
		o_dw_n <= 1'b1;
		o_ad <= ~o_ad;
		repeat (4) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] rp = 4'h0;
	logic [7:0] gp = 8'h00;
	logic [7:0] od, hd, ra, rw, rd, wa, wd;
	logic sp, cs_n, ds_n, dw_n, al, oe, wr, ro, go, mx, rr, rv, gv;
	int nrd = 0;
	logic [3:0] a;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	wire logic [7:0] bus = oe ? od : hd;
	always #5 clk = ~clk;
	hpb_host_port dut (.I_MCLK(clk), .I_RST(rst), .I_STYLE_SPLIT(sp), .I_CS_N(cs_n), .I_HOST_DATA_STROBE_N(ds_n),
		.I_DIR_OR_WR_N(dw_n), .I_ALE(al), .I_A(a), .I_AD(bus), .O_AD(od), .O_AD_OE(oe), .O_REG_WR(wr),
		.O_REG_RD(rr), .O_REG_ADDR(ra), .O_REG_WDATA(rw), .I_REG_RDATA(8'hA5 ^ ra), .I_RT_PEND(rp),
		.I_GEN_PEND(gp), .O_REALTIME_IRQ_OUT(rv), .O_REALTIME_IRQ_OUT_OE(ro), .O_IRQ_REQ(gv), .O_IRQ_REQ_OE(go),
		.O_MUX_MODE(mx));
	hpb_host_model host (.i_clk(clk), .i_oe(oe), .i_ad(bus), .o_sp(sp), .o_cs_n(cs_n), .o_ds_n(ds_n),
		.o_dw_n(dw_n), .o_al(al), .o_a(a), .o_ad(hd));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rr)
			nrd <= nrd + 1;
		if (wr) begin
			wa <= ra;
			wd <= rw;
		end
		if (cyc == 2000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_demux();
		host.xfer(1'b0, 1'b0, 1'b0, 1'b1, 8'h05, 8'h55, rd);
		for (int s = 0; s < 2; s++) begin
			host.xfer(1'b1, s[0], 1'b0, 1'b1, 8'h0F, 8'h3C + 8'(s), rd);
			chk(wa, 8'h0F);
			chk(wd, 8'h3C + 8'(s));
			host.xfer(1'b1, s[0], 1'b0, 1'b0, 8'h1A, 8'h00, rd);
			chk(rd, 8'hAF);
			chk(8'(nrd), 8'(s + 1));
		end
	endtask
	task automatic t_irq();
		for (int i = 0; i < 13; i++) begin
			{gp, rp} <= 12'h001 << i;
			repeat (2) @(posedge clk);
			chk({6'h00, ro, go}, {6'h00, i < 4, i >= 4 && i < 12});
			chk({6'h00, rv, gv}, 8'h00);
		end
	endtask
	task automatic t_mux();
		host.xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'hC3, 8'h96, rd);
		chk(wa, 8'hC3);
		chk(wd, 8'h96);
		host.xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'hE1, 8'h00, rd);
		chk(rd, 8'h44);
		chk({7'h00, mx}, 8'h01);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk({7'h00, mx}, 8'h00);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_demux();
		t_irq();
		t_mux();
		end_of_test();
	end
endmodule
`default_nettype wire
